// ### acr_access.sv
module acr_access
  import acr_pkg::*;
(
  // Request
  input  wire acr_req_t    req_i,
  input  wire logic        nonsecure_coherency_permit_i,
  input  wire logic        secure_sysctl_write_lock_i,
  // Decision
  output logic             hit_o,
  output logic             undef_o,
  output logic             wr_en_o,
  output logic [31:0]      wr_mask_o
);

  always_comb
  begin
    hit_o     = acr_hit(req_i);
    undef_o   = 1'b0;
    wr_en_o   = 1'b0;
    wr_mask_o = 32'h0000_0000;
    if (hit_o)
    begin
      if (!req_i.privileged)
        undef_o = 1'b1;
      else if (req_i.write)
      begin
        if (!req_i.nonsecure)
        begin
          if (secure_sysctl_write_lock_i)
            undef_o = 1'b1;
          else
          begin
            wr_en_o   = 1'b1;
            wr_mask_o = ACR_IMPL_MASK;
          end
        end
        else if (nonsecure_coherency_permit_i)
        begin
          wr_en_o   = 1'b1;
          wr_mask_o = ACR_COH_MASK;
        end
      end
    end
  end

endmodule

// ### acr_aux_core_control.sv
// Behaviour
// - Only privileged modes access register
// - One unbanked copy for both states
// - Secure writable; nonsecure read-only without permit
// - Nonsecure permitted writes touch coherency only
// - Locked secure write raises undefined
// - Bit 28 stops branch dual issue
// - Bit 18 disables indirect target cache
// - Bit 17 disables return stack
// - Bits 16:15 choose prediction policy
// - Bits 14:13 cap hardware prefetches
// - Bit 12 disables read allocate
// - Bit 11 disables write bursts
// - Bit 10 disables optimised barrier
// - Bit 7 selects exclusive caching
// - Exclusive: L2 fill only on evictions
// - Bit 6 treats shared as cacheable
// - Decoded at op1 0 c1 c0 op2 1
module acr_aux_core_control
  import acr_pkg::*;
#(
  parameter logic [31:0] RESET_VALUE = ACR_RESET
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Coprocessor transfer
  input  wire acr_req_t    req_i,
  output acr_rsp_t         rsp_o,
  // Security inputs
  input  wire logic        nonsecure_coherency_permit_i,
  input  wire logic        secure_sysctl_write_lock_i,
  // Line state for L2 forwarding decision
  input  wire logic        l1_evict_i,
  input  wire logic        line_wb_cacheable_i,
  input  wire logic        line_l1_allocated_i,
  // Controls to the core
  output acr_ctrl_t        ctrl_o,
  output logic             l2_fill_allow_o,
  output logic [1:0]       prefetch_limit_o
);

  logic [31:0] value_ff;
  logic [31:0] nxt_value;
  acr_rsp_t    rsp_ff;
  acr_rsp_t    nxt_rsp;
  acr_ctrl_t   ctrl_ff;
  acr_ctrl_t   nxt_ctrl;
  logic        l2_fill_ff;
  logic        nxt_l2_fill;
  logic [1:0]  pf_ff;
  logic [1:0]  nxt_pf;

  logic        hit;
  logic        undef;
  logic        wr_en;
  logic [31:0] wr_mask;
  acr_ctrl_t   dec_ctrl;

  acr_access u_access
  (
    .req_i                        (req_i),
    .nonsecure_coherency_permit_i (nonsecure_coherency_permit_i),
    .secure_sysctl_write_lock_i   (secure_sysctl_write_lock_i),
    .hit_o                        (hit),
    .undef_o                      (undef),
    .wr_en_o                      (wr_en),
    .wr_mask_o                    (wr_mask)
  );

  acr_decode u_decode
  (
    .value_i (value_ff),
    .ctrl_o  (dec_ctrl)
  );

  always_comb
  begin
    nxt_value = value_ff;
    if (wr_en)
      nxt_value = ((value_ff & ~wr_mask) | (req_i.wdata & wr_mask)) & ACR_IMPL_MASK;
  end

  always_comb
  begin
    nxt_rsp       = '0;
    nxt_rsp.done  = hit;
    nxt_rsp.undef = undef;
    if (hit && !req_i.write && !undef)
      nxt_rsp.rdata = value_ff & ACR_IMPL_MASK;
  end

  always_comb
  begin
    nxt_ctrl = dec_ctrl;
    nxt_pf   = dec_ctrl.prefetch_depth;
    // In exclusive mode L2 gets only evicted WB allocated lines
    if (dec_ctrl.exclusive_cache_mode)
      nxt_l2_fill = l1_evict_i && line_wb_cacheable_i && line_l1_allocated_i;
    else
      nxt_l2_fill = 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      value_ff   <= RESET_VALUE & ACR_IMPL_MASK;
      rsp_ff     <= '0;
      ctrl_ff    <= '0;
      l2_fill_ff <= 1'b1;
      pf_ff      <= 2'h0;
    end
    else
    begin
      value_ff   <= nxt_value;
      rsp_ff     <= nxt_rsp;
      ctrl_ff    <= nxt_ctrl;
      l2_fill_ff <= nxt_l2_fill;
      pf_ff      <= nxt_pf;
    end
  end

  assign rsp_o            = rsp_ff;
  assign ctrl_o           = ctrl_ff;
  assign l2_fill_allow_o  = l2_fill_ff;
  assign prefetch_limit_o = pf_ff;

  unpriv_no_write_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (acr_hit(req_i) && !req_i.privileged) |=> value_ff == $past(value_ff) && rsp_o.undef)
    else $error("unprivileged access not refused");

  ns_ro_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (acr_hit(req_i) && req_i.nonsecure && !nonsecure_coherency_permit_i)
      |=> value_ff == $past(value_ff))
    else $error("nonsecure write changed value without permit");

  ns_coh_only_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (acr_hit(req_i) && req_i.write && req_i.privileged && req_i.nonsecure &&
     nonsecure_coherency_permit_i)
      |=> (value_ff & ~ACR_COH_MASK) == ($past(value_ff) & ~ACR_COH_MASK) &&
          value_ff[ACR_COH_BIT] == $past(req_i.wdata[ACR_COH_BIT]))
    else $error("nonsecure permitted write wrong");

  lock_undef_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (acr_hit(req_i) && req_i.write && req_i.privileged && !req_i.nonsecure &&
     secure_sysctl_write_lock_i) |=> rsp_o.undef && $stable(value_ff))
    else $error("locked secure write not undefined");

  sec_write_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (acr_hit(req_i) && req_i.write && req_i.privileged && !req_i.nonsecure &&
     !secure_sysctl_write_lock_i) |=> value_ff == ($past(req_i.wdata) & ACR_IMPL_MASK))
    else $error("secure write not stored");

  rsvd_zero_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (rsp_o.rdata & ~ACR_IMPL_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  dual_off_a : assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ctrl_o.branch_dual_issue_off == $past(value_ff[ACR_DUAL_BIT]))
    else $error("dual issue control mismatch");

  exclusive_cache_mode_fill_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (dec_ctrl.exclusive_cache_mode && !l1_evict_i) |=> !l2_fill_allow_o)
    else $error("L2 fill without eviction in exclusive mode");

  decode_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.opc2 != ACR_OPC2) |=> !rsp_o.done)
    else $error("wrong opcode accepted");

  read_back_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (acr_hit(req_i) && !req_i.write && req_i.privileged)
      |=> rsp_o.done && rsp_o.rdata == $past(value_ff))
    else $error("read data differs from stored value");

  unpriv_nodata_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (acr_hit(req_i) && !req_i.privileged) |=> rsp_o.rdata == 32'h0000_0000)
    else $error("unprivileged access returned data");

  ns_quiet_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (acr_hit(req_i) && req_i.write && req_i.privileged && req_i.nonsecure &&
     !nonsecure_coherency_permit_i) |=> rsp_o.done && !rsp_o.undef)
    else $error("refused nonsecure write misreported");

  pf_limit_a : assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 prefetch_limit_o == $past(value_ff[ACR_PF_HI:ACR_PF_LO]))
    else $error("prefetch limit mismatch");

  coh_ctrl_a : assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ctrl_o.coherency_enable == $past(value_ff[ACR_COH_BIT]))
    else $error("coherency control mismatch");

  incl_fill_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !dec_ctrl.exclusive_cache_mode |=> l2_fill_allow_o)
    else $error("L2 fill blocked outside exclusive mode");

endmodule

// ### acr_aux_core_control_tb.sv
module acr_aux_core_control_tb
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk_i;
  logic       rst_i;
  acr_req_t   req_i;
  acr_rsp_t   rsp_o;
  acr_rsp_t   rsp;
  logic       permit;
  logic       lock;
  logic       evict;
  logic       wbc;
  logic       alloc;
  acr_ctrl_t  ctrl_o;
  logic       l2_fill_allow_o;
  logic [1:0] prefetch_limit_o;
  logic [31:0] v;
  int         n_mismatch = 0;
  int         n_tests = 0;

  acr_aux_core_control dut (
    .clk_i                        (clk_i),
    .rst_i                        (rst_i),
    .req_i                        (req_i),
    .rsp_o                        (rsp_o),
    .nonsecure_coherency_permit_i (permit),
    .secure_sysctl_write_lock_i   (lock),
    .l1_evict_i                   (evict),
    .line_wb_cacheable_i          (wbc),
    .line_l1_allocated_i          (alloc),
    .ctrl_o                       (ctrl_o),
    .l2_fill_allow_o              (l2_fill_allow_o),
    .prefetch_limit_o             (prefetch_limit_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask

  function automatic acr_ctrl_t exp_ctrl(input logic [31:0] x);
    exp_ctrl = {x[28], x[18], x[17], x[16:15], x[14:13], x[12], x[11], x[10], x[7], x[6]};
  endfunction

  // Request held through its taking edge, answer read once it has landed
  task automatic xfer(input logic wr, pr, ns, input logic [31:0] wd, input logic [2:0] o2);
    @(posedge clk_i);
    req_i <= '{valid: 1'b1, write: wr, cp_num: ACR_CP_NUM, opc1: ACR_OPC1, crn: ACR_CRN,
               crm: ACR_CRM, opc2: o2, privileged: pr, nonsecure: ns, wdata: wd};
    @(posedge clk_i);
    req_i.valid <= 1'b0;
    #1 rsp = rsp_o;
  endtask

  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask

  task automatic rd_chk(input logic ns, input logic [31:0] exp);
    xfer(1'b0, 1'b1, ns, 32'h0, ACR_OPC2);
    chk_bit(rsp.done, 1'b1);
    chk_word(rsp.rdata, exp);
  endtask

  task automatic wr_s(input logic [31:0] x);
    xfer(1'b1, 1'b1, 1'b0, x, ACR_OPC2);
    chk_bit(rsp.done, 1'b1);
    settle();
  endtask

  // Lone bit catches swapped fields that all-ones hides
  task automatic one_bit(input int b);
    logic [31:0] w;
    w = 32'h1 << b;
    wr_s(w);
    chk_word(32'(ctrl_o), 32'(exp_ctrl(w)));
    rd_chk(1'b1, w);
  endtask

  // Software side: read, set wanted bits, write the rest back
  task automatic rmw(input logic [31:0] set_m, input logic [31:0] exp);
    xfer(1'b0, 1'b1, 1'b0, 32'h0, ACR_OPC2);
    wr_s(rsp.rdata | set_m);
    rd_chk(1'b0, exp);
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Whole sequence needs about 130 cycles
  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    rst_i = 1'b1;
    req_i = '0;
    {permit, lock, evict, wbc, alloc} = 5'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    chk_bit(l2_fill_allow_o, 1'b1);
    rd_chk(1'b0, 32'h0);
    wr_s(32'hffff_ffff);
    chk_word(32'(ctrl_o), 32'(exp_ctrl(ACR_IMPL_MASK)));
    rd_chk(1'b0, ACR_IMPL_MASK);
    rd_chk(1'b1, ACR_IMPL_MASK);
    xfer(1'b1, 1'b1, 1'b1, 32'h0, ACR_OPC2);
    chk_bit(rsp.undef, 1'b0);
    rd_chk(1'b0, ACR_IMPL_MASK);
    permit <= 1'b1;
    xfer(1'b1, 1'b1, 1'b1, 32'h0, ACR_OPC2);
    rd_chk(1'b1, ACR_IMPL_MASK & ~ACR_COH_MASK);
    xfer(1'b1, 1'b1, 1'b1, 32'hffff_ffff, ACR_OPC2);
    rd_chk(1'b1, ACR_IMPL_MASK);
    permit <= 1'b0;
    lock <= 1'b1;
    xfer(1'b1, 1'b1, 1'b0, 32'h0, ACR_OPC2);
    chk_bit(rsp.undef, 1'b1);
    lock <= 1'b0;
    rd_chk(1'b0, ACR_IMPL_MASK);
    xfer(1'b1, 1'b0, 1'b0, 32'h0, ACR_OPC2);
    chk_bit(rsp.undef, 1'b1);
    xfer(1'b0, 1'b0, 1'b1, 32'h0, ACR_OPC2);
    chk_bit(rsp.undef, 1'b1);
    rd_chk(1'b0, ACR_IMPL_MASK);
    for (int i = 0; i < 8; i++)
    begin
      if (i != 1)
      begin
        xfer(1'b1, 1'b1, 1'b0, 32'h0, 3'(i));
        chk_bit(rsp.done, 1'b0);
      end
    end
    rd_chk(1'b0, ACR_IMPL_MASK);
    // Every policy and prefetch code, both fields at once
    for (int i = 0; i < 4; i++)
    begin
      v = (32'(i) << ACR_BP_LO) | (32'(i) << ACR_PF_LO);
      wr_s(v);
      chk_word(32'(ctrl_o), 32'(exp_ctrl(v)));
      chk_word(32'(prefetch_limit_o), 32'(i));
    end
    one_bit(ACR_DUAL_BIT);
    one_bit(ACR_ITC_BIT);
    one_bit(ACR_RS_BIT);
    one_bit(ACR_RA_BIT);
    one_bit(ACR_WB_BIT);
    one_bit(ACR_DMB_BIT);
    one_bit(ACR_EXCLUSIVE_CACHE_MODE_BIT);
    one_bit(ACR_COH_BIT);
    rmw(32'h0000_0400, 32'h0000_0440);
    wr_s(32'h0000_0080);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      {evict, wbc, alloc} <= 3'(i);
      settle();
      chk_bit(l2_fill_allow_o, i == 7);
    end
    wr_s(32'h0);
    chk_bit(l2_fill_allow_o, 1'b1);
    final_report();
  end
endmodule

// ### acr_decode.sv
module acr_decode
  import acr_pkg::*;
(
  // Stored value
  input  wire logic [31:0] value_i,
  // Fields
  output acr_ctrl_t        ctrl_o
);

  always_comb
  begin
    ctrl_o.branch_dual_issue_off     = value_i[ACR_DUAL_BIT];
    ctrl_o.indirect_target_cache_off = value_i[ACR_ITC_BIT];
    ctrl_o.return_stack_off          = value_i[ACR_RS_BIT];
    ctrl_o.prediction_policy         = acr_bp_t'(value_i[ACR_BP_HI:ACR_BP_LO]);
    ctrl_o.prefetch_depth            = value_i[ACR_PF_HI:ACR_PF_LO];
    ctrl_o.read_allocate_off         = value_i[ACR_RA_BIT];
    ctrl_o.write_burst_off           = value_i[ACR_WB_BIT];
    ctrl_o.barrier_optimisation_off  = value_i[ACR_DMB_BIT];
    ctrl_o.exclusive_cache_mode      = value_i[ACR_EXCLUSIVE_CACHE_MODE_BIT];
    ctrl_o.coherency_enable          = value_i[ACR_COH_BIT];
  end

endmodule

// ### acr_pkg.sv
package acr_pkg;

  localparam int ACR_W = 32;

  // Coprocessor decode of the register
  localparam logic [3:0] ACR_CP_NUM  = 4'hf;
  localparam logic [2:0] ACR_OPC1    = 3'h0;
  localparam logic [3:0] ACR_CRN     = 4'h1;
  localparam logic [3:0] ACR_CRM     = 4'h0;
  localparam logic [2:0] ACR_OPC2    = 3'h1;

  // Field positions
  localparam int ACR_DUAL_BIT   = 28;
  localparam int ACR_ITC_BIT    = 18;
  localparam int ACR_RS_BIT     = 17;
  localparam int ACR_BP_HI      = 16;
  localparam int ACR_BP_LO      = 15;
  localparam int ACR_PF_HI      = 14;
  localparam int ACR_PF_LO      = 13;
  localparam int ACR_RA_BIT     = 12;
  localparam int ACR_WB_BIT     = 11;
  localparam int ACR_DMB_BIT    = 10;
  localparam int ACR_EXCLUSIVE_CACHE_MODE_BIT   = 7;
  localparam int ACR_COH_BIT    = 6;

  // Implemented bits; everything else reads zero
  localparam logic [31:0] ACR_IMPL_MASK = 32'h1007_fcc0;
  localparam logic [31:0] ACR_COH_MASK  = 32'h0000_0040;
  localparam logic [31:0] ACR_RESET     = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    ACR_BP_NORMAL    = 2'h0,
    ACR_BP_TAKEN     = 2'h1,
    ACR_BP_NOT_TAKEN = 2'h2,
    ACR_BP_RSVD      = 2'h3
  } acr_bp_t;

  typedef struct packed
  {
    logic       valid;
    logic       write;
    logic [3:0] cp_num;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic       privileged;
    logic       nonsecure;
    logic [31:0] wdata;
  } acr_req_t;

  typedef struct packed
  {
    logic        done;
    logic        undef;
    logic [31:0] rdata;
  } acr_rsp_t;

  typedef struct packed
  {
    logic        branch_dual_issue_off;
    logic        indirect_target_cache_off;
    logic        return_stack_off;
    acr_bp_t     prediction_policy;
    logic [1:0]  prefetch_depth;
    logic        read_allocate_off;
    logic        write_burst_off;
    logic        barrier_optimisation_off;
    logic        exclusive_cache_mode;
    logic        coherency_enable;
  } acr_ctrl_t;

  function automatic logic acr_hit(input acr_req_t r);
    return r.valid && r.cp_num == ACR_CP_NUM && r.opc1 == ACR_OPC1 &&
           r.crn == ACR_CRN && r.crm == ACR_CRM && r.opc2 == ACR_OPC2;
  endfunction

endpackage
